// ---- hw/dstc_top.sv ----
// summer/winter time conversion, running clock and time-of-day distribution with APB registers
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module dstc_top #(
  parameter int unsigned TICK_CYCLES = dstc_pkg::TICK_CYCLES
) (
  input  wire  logic                pclk,
  input  wire  logic                presetn,
  input  wire  logic                psel,
  input  wire  logic                penable,
  input  wire  logic                pwrite,
  input  wire  logic [7:0]          paddr,
  input  wire  logic [31:0]         pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire  dstc_pkg::dstc_op_t  op_mode,
  input  wire  logic                sync_valid,
  input  wire  dstc_pkg::dstc_tod_t sync_tod,
  output logic                      tod_valid,
  input  wire  logic                tod_ready,
  output dstc_pkg::dstc_tod_t       tod_out,
  output logic                      summer
);

  localparam int CW = $clog2(TICK_CYCLES);

  dstc_pkg::dstc_mode_t mode_r;
  dstc_pkg::dstc_md_t   ustart_r, uend_r;
  dstc_pkg::dstc_tod_t  tod_r, nxt;
  logic [7:0]           uoff_r;
  logic                 sync_en_r, summer_r, pend_r;
  logic [CW-1:0]        cnt_r;
  logic [31:0]          prdata_r, rd_mux;
  logic                 tick, run_ok, day_end, hit_ok, hour_roll;
  logic                 acc, wr, setup, fwd_fire, bwd_fire, set_time, set_date, load_sync;
  logic                 start_hit, end_hit;
  logic [4:0]           start_hour, end_hour;
  logic [7:0]           step;
  logic [10:0]          mod_fwd, mod_bwd;

  // =======================================================
  // APB slave: zero wait states, read data captured in setup
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign setup  = psel && !penable;
  assign pready = 1'b1;
  assign prdata = prdata_r;

  always_comb begin
    hit_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      dstc_pkg::OFF_CTRL: begin
        rd_mux[dstc_pkg::CTRL_MODE_LSB +: 4] = mode_r;
        rd_mux[dstc_pkg::CTRL_SYNC_BIT]      = sync_en_r;
      end
      dstc_pkg::OFF_USTART: begin
        rd_mux[dstc_pkg::MD_MON_LSB +: 4] = ustart_r.month;
        rd_mux[dstc_pkg::MD_DAY_LSB +: 5] = ustart_r.day;
      end
      dstc_pkg::OFF_UEND: begin
        rd_mux[dstc_pkg::MD_MON_LSB +: 4] = uend_r.month;
        rd_mux[dstc_pkg::MD_DAY_LSB +: 5] = uend_r.day;
      end
      dstc_pkg::OFF_UOFF: rd_mux[7:0] = uoff_r;
      dstc_pkg::OFF_TIME: begin
        rd_mux[dstc_pkg::TIME_SEC_LSB +: 6]  = tod_r.sec;
        rd_mux[dstc_pkg::TIME_MIN_LSB +: 6]  = tod_r.min;
        rd_mux[dstc_pkg::TIME_HOUR_LSB +: 5] = tod_r.hour;
      end
      dstc_pkg::OFF_DATE: begin
        rd_mux[dstc_pkg::DATE_DAY_LSB +: 5]  = tod_r.day;
        rd_mux[dstc_pkg::DATE_MON_LSB +: 4]  = tod_r.month;
        rd_mux[dstc_pkg::DATE_YEAR_LSB +: 7] = tod_r.year;
        rd_mux[dstc_pkg::DATE_WDAY_LSB +: 3] = tod_r.wday;
      end
      dstc_pkg::OFF_STAT: begin
        rd_mux[dstc_pkg::STAT_SUM_BIT]     = summer_r;
        rd_mux[dstc_pkg::STAT_OP_LSB +: 2] = op_mode;
        rd_mux[dstc_pkg::STAT_PEND_BIT]    = pend_r;
      end
      default: hit_ok = 1'b0;
    endcase
  end

  assign pslverr = acc && !hit_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // =======================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r    <= dstc_pkg::MODE_RST;
      sync_en_r <= 1'b0;
    end else if (wr && paddr == dstc_pkg::OFF_CTRL) begin
      // undefined rule codes fall back to off rather than to a guess
      if (pwdata[dstc_pkg::CTRL_MODE_LSB +: 4] > dstc_pkg::DST_USER) begin
        mode_r <= dstc_pkg::DST_OFF;
      end else begin
        mode_r <= dstc_pkg::dstc_mode_t'(pwdata[dstc_pkg::CTRL_MODE_LSB +: 4]);
      end
      sync_en_r <= pwdata[dstc_pkg::CTRL_SYNC_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ustart_r <= dstc_pkg::UMD_RST;
      uend_r   <= dstc_pkg::UMD_RST;
      uoff_r   <= dstc_pkg::UOFF_RST;
    end else if (wr) begin
      if (paddr == dstc_pkg::OFF_USTART) begin
        ustart_r.month <= pwdata[dstc_pkg::MD_MON_LSB +: 4];
        ustart_r.day   <= pwdata[dstc_pkg::MD_DAY_LSB +: 5];
      end
      if (paddr == dstc_pkg::OFF_UEND) begin
        uend_r.month <= pwdata[dstc_pkg::MD_MON_LSB +: 4];
        uend_r.day   <= pwdata[dstc_pkg::MD_DAY_LSB +: 5];
      end
      // an offset beyond the range is dropped, the old value stays
      if (paddr == dstc_pkg::OFF_UOFF && pwdata[31:0] <= {24'h00_0000, dstc_pkg::UOFF_MAX}) begin
        uoff_r <= pwdata[7:0];
      end
    end
  end

  // =======================================================
  // seconds prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(TICK_CYCLES - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign tick = (cnt_r == CW'(TICK_CYCLES - 1));

  // =======================================================
  // next second of the running clock
  always_comb begin
    nxt     = tod_r;
    day_end = 1'b0;
    if (tod_r.sec != dstc_pkg::SEC_MAX) begin
      nxt.sec = tod_r.sec + 6'h01;
    end else begin
      nxt.sec = 6'h00;
      if (tod_r.min != dstc_pkg::MIN_MAX) begin
        nxt.min = tod_r.min + 6'h01;
      end else begin
        nxt.min = 6'h00;
        if (tod_r.hour != dstc_pkg::HOUR_MAX) begin
          nxt.hour = tod_r.hour + 5'h01;
        end else begin
          nxt.hour = 5'h00;
          day_end  = 1'b1;
        end
      end
    end
    if (day_end) begin
      nxt.wday = (tod_r.wday == dstc_pkg::WDAY_MAX) ? 3'h0 : tod_r.wday + 3'h1;
      if (tod_r.day != dstc_pkg::dstc_dim(tod_r.month, tod_r.year)) begin
        nxt.day = tod_r.day + 5'h01;
      end else begin
        nxt.day = 5'h01;
        if (tod_r.month != dstc_pkg::MON_MAX) begin
          nxt.month = tod_r.month + 4'h1;
        end else begin
          nxt.month = 4'h1;
          nxt.year  = (tod_r.year == dstc_pkg::YEAR_MAX) ? 7'h00 : tod_r.year + 7'h01;
        end
      end
    end
  end

  // =======================================================
  // conversion
  dstc_rule_sel u_rule (
    .mode       (mode_r),
    .ustart     (ustart_r),
    .uend       (uend_r),
    .uoff       (uoff_r),
    .now        (tod_r),
    .start_hit  (start_hit),
    .end_hit    (end_hit),
    .start_hour (start_hour),
    .end_hour   (end_hour),
    .step       (step)
  );

  assign run_ok  = (op_mode == dstc_pkg::OP_RUN) || (op_mode == dstc_pkg::OP_STOP);
  assign mod_fwd = 11'(start_hour) * dstc_pkg::MIN_PER_HOUR + 11'(step);
  assign mod_bwd = 11'(end_hour) * dstc_pkg::MIN_PER_HOUR - 11'(step);

  // the summer flag is what stops the repeated hour from stepping back twice
  assign fwd_fire = tick && run_ok && start_hit && !summer_r && nxt.hour == start_hour &&
                    nxt.min == 6'h00 && nxt.sec == 6'h00;
  assign bwd_fire = tick && run_ok && end_hit && summer_r && nxt.hour == end_hour &&
                    nxt.min == 6'h00 && nxt.sec == 6'h00;

  assign set_time  = wr && paddr == dstc_pkg::OFF_TIME;
  assign set_date  = wr && paddr == dstc_pkg::OFF_DATE;
  assign load_sync = sync_valid && sync_en_r && !set_time && !set_date;

  // bus writes win over a module sync, which wins over the running second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tod_r <= dstc_pkg::TOD_RST;
    end else if (set_time || set_date) begin
      if (set_time) begin
        tod_r.sec  <= pwdata[dstc_pkg::TIME_SEC_LSB +: 6];
        tod_r.min  <= pwdata[dstc_pkg::TIME_MIN_LSB +: 6];
        tod_r.hour <= pwdata[dstc_pkg::TIME_HOUR_LSB +: 5];
      end
      if (set_date) begin
        tod_r.day   <= pwdata[dstc_pkg::DATE_DAY_LSB +: 5];
        tod_r.month <= pwdata[dstc_pkg::DATE_MON_LSB +: 4];
        tod_r.year  <= pwdata[dstc_pkg::DATE_YEAR_LSB +: 7];
        tod_r.wday  <= pwdata[dstc_pkg::DATE_WDAY_LSB +: 3];
      end
    end else if (load_sync) begin
      tod_r <= sync_tod;
    end else if (fwd_fire) begin
      tod_r.sec  <= 6'h00;
      tod_r.hour <= 5'(mod_fwd / dstc_pkg::MIN_PER_HOUR);
      tod_r.min  <= 6'(mod_fwd % dstc_pkg::MIN_PER_HOUR);
    end else if (bwd_fire) begin
      tod_r.sec  <= 6'h00;
      tod_r.hour <= 5'(mod_bwd / dstc_pkg::MIN_PER_HOUR);
      tod_r.min  <= 6'(mod_bwd % dstc_pkg::MIN_PER_HOUR);
    end else if (tick) begin
      tod_r <= nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summer_r <= 1'b0;
    end else if (fwd_fire && !set_time && !set_date && !load_sync) begin
      summer_r <= 1'b1;
    end else if (bwd_fire && !set_time && !set_date && !load_sync) begin
      summer_r <= 1'b0;
    end else if (mode_r == dstc_pkg::DST_OFF) begin
      summer_r <= 1'b0;
    end
  end

  assign summer = summer_r;

  // =======================================================
  // time-of-day distribution to expansion modules
  assign hour_roll = tick && run_ok && nxt.min == 6'h00 && nxt.sec == 6'h00;

  // pending starts set so the first send follows power-up; a new event beats the ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b1;
    end else if (hour_roll || fwd_fire || bwd_fire || set_time || set_date || load_sync) begin
      pend_r <= 1'b1;
    end else if (tod_ready) begin
      pend_r <= 1'b0;
    end
  end

  assign tod_valid = pend_r;
  assign tod_out   = tod_r;

  // =======================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic first_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  AST_DEFAULTS_OFF: assert property (first_r |-> mode_r == dstc_pkg::DST_OFF && !summer_r)
    else $error("conversion not off after reset");
  AST_SYNC_DEFAULT: assert property (first_r |-> !sync_en_r && tod_valid)
    else $error("sync enabled or no power-up send");
  AST_EU_FWD: assert property ((fwd_fire && mode_r == dstc_pkg::DST_EU && !set_time && !set_date &&
                                !load_sync) |=> tod_r.hour == dstc_pkg::HOUR_3 && tod_r.min == 6'h00)
    else $error("european forward step wrong");
  AST_UK_BACK: assert property ((bwd_fire && mode_r == dstc_pkg::DST_UK && !set_time && !set_date &&
                                 !load_sync) |=> tod_r.hour == dstc_pkg::HOUR_1 && !summer_r)
    else $error("uk backward step wrong");
  AST_US_BACK_HOUR: assert property ((bwd_fire && mode_r == dstc_pkg::DST_US) |->
                                     tod_r.hour == dstc_pkg::HOUR_1 && tod_r.month == dstc_pkg::MON_NOV)
    else $error("us backward step at wrong time");
  AST_OFFSET_RANGE: assert property (uoff_r <= dstc_pkg::UOFF_MAX)
    else $error("user offset above range");
  AST_NO_BACKUP_CONV: assert property ((fwd_fire || bwd_fire) |-> op_mode != dstc_pkg::OP_BACKUP)
    else $error("conversion while on backup power");
  AST_SYNC_LOAD: assert property ((sync_valid && sync_en_r && !set_time && !set_date) |=>
                                  tod_r == $past(sync_tod) && tod_valid)
    else $error("module time not taken");
  AST_SYNC_IGNORED: assert property ((sync_valid && !sync_en_r && !tick && !wr) |=> $stable(tod_r))
    else $error("module time taken while sync off");
  AST_HOURLY_SEND: assert property ((tick && run_ok && tod_r.min == dstc_pkg::MIN_MAX &&
                                     tod_r.sec == dstc_pkg::SEC_MAX) |=> tod_valid)
    else $error("hourly send missing");
  AST_BACK_ONCE: assert property (bwd_fire && !set_time && !set_date && !load_sync |=>
                                  (!fwd_fire && !bwd_fire) [*2])
    else $error("backward step repeated");

  COV_FWD: cover property (fwd_fire);
  COV_BWD: cover property (bwd_fire);
  COV_SYNC: cover property (load_sync);
  COV_SEND: cover property (tod_valid && tod_ready);

endmodule // dstc_top

// ---- hw/dstc_pkg.sv ----
// constants, types and helpers for the summer/winter conversion and time distribution block
package dstc_pkg;

  // =======================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned TICK_CYCLES   = SEC_NS / CLK_PERIOD_NS;

  // =======================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_USTART = 8'h04;
  localparam logic [7:0] OFF_UEND   = 8'h08;
  localparam logic [7:0] OFF_UOFF   = 8'h0C;
  localparam logic [7:0] OFF_TIME   = 8'h10;
  localparam logic [7:0] OFF_DATE   = 8'h14;
  localparam logic [7:0] OFF_STAT   = 8'h18;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int MD_MON_LSB    = 0;
  localparam int MD_DAY_LSB    = 8;
  localparam int TIME_SEC_LSB  = 0;
  localparam int TIME_MIN_LSB  = 8;
  localparam int TIME_HOUR_LSB = 16;
  localparam int DATE_DAY_LSB  = 0;
  localparam int DATE_MON_LSB  = 8;
  localparam int DATE_YEAR_LSB = 16;
  localparam int DATE_WDAY_LSB = 24;
  localparam int STAT_SUM_BIT  = 0;
  localparam int STAT_OP_LSB   = 1;
  localparam int STAT_PEND_BIT = 3;

  // =======================================================
  // calendar limits and preset figures
  localparam logic [5:0]  SEC_MAX      = 6'h3B;
  localparam logic [5:0]  MIN_MAX      = 6'h3B;
  localparam logic [4:0]  HOUR_MAX     = 5'h17;
  localparam logic [3:0]  MON_MAX      = 4'hC;
  localparam logic [6:0]  YEAR_MAX     = 7'h63;
  localparam logic [2:0]  WDAY_MAX     = 3'h6;
  localparam logic [2:0]  WDAY_SUN     = 3'h0;
  localparam logic [10:0] MIN_PER_HOUR = 11'h03C;
  localparam logic [4:0]  HOUR_1       = 5'h01;
  localparam logic [4:0]  HOUR_2       = 5'h02;
  localparam logic [4:0]  HOUR_3       = 5'h03;
  localparam logic [3:0]  MON_MAR      = 4'h3;
  localparam logic [3:0]  MON_APR      = 4'h4;
  localparam logic [3:0]  MON_OCT      = 4'hA;
  localparam logic [3:0]  MON_NOV      = 4'hB;
  localparam logic [7:0]  STEP_STD     = 8'h3C;
  localparam logic [7:0]  UOFF_MAX     = 8'hB4;
  localparam logic [7:0]  UOFF_RST     = 8'h3C;

  typedef enum logic [3:0] {
    DST_OFF = 4'h0, DST_EU = 4'h1, DST_UK = 4'h2, DST_US_OLD = 4'h3, DST_US = 4'h4,
    DST_AU = 4'h5, DST_TAS = 4'h6, DST_NZ = 4'h7, DST_USER = 4'h8
  } dstc_mode_t;

  typedef enum logic [2:0] {
    WK_FIRST = 3'h0, WK_SECOND = 3'h1, WK_THIRD = 3'h2, WK_LAST = 3'h3, WK_DAY = 3'h4
  } dstc_week_t;

  typedef enum logic [1:0] {
    OP_RUN = 2'h0, OP_STOP = 2'h1, OP_BACKUP = 2'h2
  } dstc_op_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } dstc_tod_t;

  typedef struct packed {
    logic [3:0] month;
    logic [4:0] day;
  } dstc_md_t;

  localparam dstc_tod_t TOD_RST = '{year: 7'h00, month: 4'h1, day: 5'h01, wday: 3'h6,
                                    hour: 5'h00, min: 6'h00, sec: 6'h00};
  localparam dstc_mode_t MODE_RST = DST_OFF;
  localparam dstc_md_t   UMD_RST  = '{month: 4'h1, day: 5'h01};

  // year counts from 2000, so every fourth year is a leap year
  function automatic logic [4:0] dstc_dim(input logic [3:0] mon, input logic [6:0] year);
    case (mon)
      4'h2:                      dstc_dim = (year[1:0] == 2'b00) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    dstc_dim = 5'h1E;
      default:                   dstc_dim = 5'h1F;
    endcase
  endfunction

endpackage

// ---- hw/dstc_rule_sel.sv ----
// selects the active conversion rule and matches today's date against it
`timescale 1ns/1ps
module dstc_rule_sel (
  input  dstc_pkg::dstc_mode_t mode,
  input  dstc_pkg::dstc_md_t   ustart,
  input  dstc_pkg::dstc_md_t   uend,
  input  logic [7:0]           uoff,
  input  dstc_pkg::dstc_tod_t  now,
  output logic                 start_hit,
  output logic                 end_hit,
  output logic [4:0]           start_hour,
  output logic [4:0]           end_hour,
  output logic [7:0]           step
);

  dstc_pkg::dstc_week_t ssel, esel;
  logic [3:0]           smon, emon;
  logic [4:0]           dim;

  // =======================================================
  // rule table
  always_comb begin
    ssel       = dstc_pkg::WK_LAST;
    esel       = dstc_pkg::WK_LAST;
    smon       = dstc_pkg::MON_MAR;
    emon       = dstc_pkg::MON_OCT;
    start_hour = dstc_pkg::HOUR_2;
    end_hour   = dstc_pkg::HOUR_3;
    step       = dstc_pkg::STEP_STD;
    case (mode)
      dstc_pkg::DST_EU: begin
      end
      dstc_pkg::DST_UK: begin
        start_hour = dstc_pkg::HOUR_1;
        end_hour   = dstc_pkg::HOUR_2;
      end
      dstc_pkg::DST_US_OLD: begin
        ssel     = dstc_pkg::WK_FIRST;
        smon     = dstc_pkg::MON_APR;
        end_hour = dstc_pkg::HOUR_2;
      end
      dstc_pkg::DST_US: begin
        ssel     = dstc_pkg::WK_SECOND;
        esel     = dstc_pkg::WK_FIRST;
        emon     = dstc_pkg::MON_NOV;
        end_hour = dstc_pkg::HOUR_2;
      end
      dstc_pkg::DST_AU: begin
        smon = dstc_pkg::MON_OCT;
        emon = dstc_pkg::MON_MAR;
      end
      dstc_pkg::DST_TAS: begin
        ssel = dstc_pkg::WK_FIRST;
        smon = dstc_pkg::MON_OCT;
        emon = dstc_pkg::MON_MAR;
      end
      dstc_pkg::DST_NZ: begin
        ssel = dstc_pkg::WK_FIRST;
        esel = dstc_pkg::WK_THIRD;
        smon = dstc_pkg::MON_OCT;
        emon = dstc_pkg::MON_MAR;
      end
      dstc_pkg::DST_USER: begin
        ssel = dstc_pkg::WK_DAY;
        esel = dstc_pkg::WK_DAY;
        smon = ustart.month;
        emon = uend.month;
        step = uoff;
      end
      default: begin
      end
    endcase
  end

  // =======================================================
  // date match
  function automatic logic week_ok(input dstc_pkg::dstc_week_t sel, input logic [4:0] day,
                                   input logic [4:0] udays, input logic [4:0] mdays,
                                   input logic [2:0] wday);
    logic sun;
    sun = (wday == dstc_pkg::WDAY_SUN);
    case (sel)
      dstc_pkg::WK_FIRST:  week_ok = sun && (day <= 5'h07);
      dstc_pkg::WK_SECOND: week_ok = sun && (day >= 5'h08) && (day <= 5'h0E);
      dstc_pkg::WK_THIRD:  week_ok = sun && (day >= 5'h0F) && (day <= 5'h15);
      dstc_pkg::WK_LAST:   week_ok = sun && ({1'b0, day} + 6'h07 > {1'b0, mdays});
      dstc_pkg::WK_DAY:    week_ok = (day == udays);
      default:             week_ok = 1'b0;
    endcase
  endfunction

  assign dim       = dstc_pkg::dstc_dim(now.month, now.year);
  assign start_hit = (mode != dstc_pkg::DST_OFF) && (now.month == smon) &&
                     week_ok(ssel, now.day, ustart.day, dim, now.wday);
  assign end_hit   = (mode != dstc_pkg::DST_OFF) && (now.month == emon) &&
                     week_ok(esel, now.day, uend.day, dim, now.wday);

endmodule // dstc_rule_sel

// ---- sim/dstc_mod_model.sv ----
// model of the expansion and communications modules on the time-of-day bus
`timescale 1ns/1ps
module dstc_mod_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                slow,
  input  wire logic                fire,
  input  wire dstc_pkg::dstc_tod_t fire_tod,
  input  wire logic                tod_valid,
  output logic                     tod_ready,
  output logic                     sync_valid,
  output dstc_pkg::dstc_tod_t      sync_tod,
  output int                       sends
);
  logic [1:0] stall_r;
  // ==========
  // expansion side: a slow module keeps ready low for three cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_r <= 2'h0;
      sends   <= 0;
    end else if (tod_valid && tod_ready) begin
      stall_r <= 2'h0;
      sends   <= sends + 1;
    end else if (tod_valid) begin
      stall_r <= stall_r + 2'h1;
    end
  end
  assign tod_ready = tod_valid && (!slow || stall_r == 2'h3);
  // ==========
  // comms side: data toggles outside the pulse so stale values never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_valid <= 1'b0;
      sync_tod   <= '0;
    end else begin
      sync_valid <= fire;
      sync_tod   <= fire ? fire_tod : ~sync_tod;
    end
  end
endmodule // dstc_mod_model

// ---- sim/tb_dstc_top.sv ----
// self-checking bench for the conversion and time distribution block
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; $display("[FAIL] %s expected %0h seen %0h", n, e, s); end end
module tb_dstc_top;
  typedef struct packed {logic [3:0] mode; logic [3:0] mon; logic [4:0] day; logic [4:0] hb; logic [4:0] he;} dstc_row_t;
  // ==========
  // stimulus and wiring
  localparam int unsigned T = 4;
  logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                slow = 1'b0, fire = 1'b0, pready, pslverr, tod_valid, tod_ready, sync_valid, summer, err;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata, q;
  dstc_pkg::dstc_op_t  op_mode = dstc_pkg::OP_RUN;
  dstc_pkg::dstc_tod_t sync_tod, tod_out, fire_tod = '0;
  int                  sends, s0, mismatches = 0, num_checks = 0;
  dstc_row_t rows [8] = '{'{4'h1, 4'h3, 5'h1F, 5'h01, 5'h03}, '{4'h2, 4'h3, 5'h1F, 5'h00, 5'h02},
    '{4'h3, 4'h4, 5'h07, 5'h01, 5'h03}, '{4'h4, 4'h3, 5'h0A, 5'h01, 5'h03}, '{4'h5, 4'hA, 5'h1B, 5'h01, 5'h03},
    '{4'h6, 4'hA, 5'h06, 5'h01, 5'h03}, '{4'h7, 4'hA, 5'h06, 5'h01, 5'h03}, '{4'h8, 4'h3, 5'h1F, 5'h01, 5'h04}};
  always #12.5 pclk = ~pclk;
  dstc_top #(.TICK_CYCLES(T)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_mode(op_mode), .sync_valid(sync_valid), .sync_tod(sync_tod), .tod_valid(tod_valid),
    .tod_ready(tod_ready), .tod_out(tod_out), .summer(summer));
  dstc_mod_model u_mod (.pclk(pclk), .presetn(presetn), .slow(slow), .fire(fire), .fire_tod(fire_tod),
    .tod_valid(tod_valid), .tod_ready(tod_ready), .sync_valid(sync_valid), .sync_tod(sync_tod), .sends(sends));
  // ==========
  // tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic setdt(input logic [3:0] mo, input logic [4:0] dy, input logic [4:0] h, input logic [5:0] m);
    wr(dstc_pkg::OFF_DATE, {9'h000, 7'h18, 4'h0, mo, 3'h0, dy});
    wr(dstc_pkg::OFF_TIME, {11'h000, h, 2'h0, m, 8'h3B});
  endtask
  task automatic wait_sum(input logic v);
    int n;
    num_checks++;
    for (n = 0; n < 64 && summer !== v; n++) @(posedge pclk);
    if (summer !== v) begin
      mismatches++;
      $display("[FAIL] summer expected %0h seen %0h", v, summer);
      report_and_stop();
    end
  endtask
  function automatic logic [10:0] hm(input logic [31:0] w);
    return {w[20:16], w[13:8]};
  endfunction
  // ==========
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    `CHK("tod_valid", 1'b1, tod_valid)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, dstc_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, q)
    `CHK("sends", 1, sends)
    wr(dstc_pkg::OFF_UOFF, 32'hB5);
    apb(1'b0, dstc_pkg::OFF_UOFF, 32'h0);
    `CHK("uoff", 32'h3C, q)
    wr(dstc_pkg::OFF_UOFF, 32'hB4);
    apb(1'b0, dstc_pkg::OFF_UOFF, 32'h0);
    `CHK("uoff", 32'hB4, q)
    wr(dstc_pkg::OFF_UOFF, 32'h78);
    $display("test reset done");
    foreach (rows[i]) begin
      op_mode <= (i % 2) ? dstc_pkg::OP_STOP : dstc_pkg::OP_RUN;
      wr(dstc_pkg::OFF_CTRL, 32'h0);
      wr(dstc_pkg::OFF_USTART, {19'h0, rows[i].day, 4'h0, rows[i].mon});
      wr(dstc_pkg::OFF_CTRL, {28'h0, rows[i].mode});
      setdt(rows[i].mon, rows[i].day, rows[i].hb, 6'h3B);
      wait_sum(1'b1);
      apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
      `CHK("fwd", {rows[i].he, 6'h00}, hm(q))
    end
    $display("test forward done");
    wr(dstc_pkg::OFF_UEND, {19'h0, 5'h1B, 8'h0A});
    setdt(4'hA, 5'h1B, 5'h02, 6'h3B);
    wait_sum(1'b0);
    apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
    `CHK("back_user", {5'h01, 6'h00}, hm(q))
    wr(dstc_pkg::OFF_CTRL, 32'h1);
    setdt(4'h3, 5'h1F, 5'h01, 6'h3B);
    wait_sum(1'b1);
    setdt(4'hA, 5'h1B, 5'h02, 6'h3B);
    wait_sum(1'b0);
    apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
    `CHK("back_eu", {5'h02, 6'h00}, hm(q))
    slow <= 1'b1;
    s0 = sends;
    repeat (3600 * T) @(posedge pclk);
    apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
    `CHK("repeat_hour", {5'h03, 6'h00}, hm(q))
    `CHK("summer", 1'b0, summer)
    `CHK("hourly", 1, sends - s0)
    $display("test backward done");
    op_mode <= dstc_pkg::OP_BACKUP;
    setdt(4'h3, 5'h1F, 5'h01, 6'h3B);
    repeat (8 * T) @(posedge pclk);
    `CHK("backup", 1'b0, summer)
    op_mode <= dstc_pkg::OP_RUN;
    fire_tod <= {7'h18, 4'h6, 5'h0F, 3'h6, 5'h0B, 6'h21, 6'h00};
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
    `CHK("sync_off", {5'h02, 6'h00}, hm(q))
    wr(dstc_pkg::OFF_CTRL, 32'h11);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
    `CHK("sync_on", {5'h0B, 6'h21}, hm(q))
    `CHK("tod_out", {5'h0B, 6'h21}, {tod_out.hour, tod_out.min})
    // uk then current us: both step back to 01:00
    for (int j = 0; j < 2; j++) begin
      wr(dstc_pkg::OFF_CTRL, j ? 32'h4 : 32'h2);
      setdt(4'h3, j ? 5'h0A : 5'h1F, j ? 5'h01 : 5'h00, 6'h3B);
      wait_sum(1'b1);
      setdt(j ? 4'hB : 4'hA, j ? 5'h03 : 5'h1B, 5'h01, 6'h3B);
      wait_sum(1'b0);
      apb(1'b0, dstc_pkg::OFF_TIME, 32'h0);
      `CHK("back_uk_us", {5'h01, 6'h00}, hm(q))
    end
    wr(dstc_pkg::OFF_CTRL, 32'h9);
    apb(1'b0, dstc_pkg::OFF_CTRL, 32'h0);
    `CHK("bad_mode", 32'h0, q)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, q)
    $display("test backup sync bus done");
    report_and_stop();
  end
endmodule // tb_dstc_top
